// ---- core/phssl_pkg.sv ----
/*
 * package for the port c handshake status logic: register offsets,
 * field positions and the channel-to-pin and channel-to-register maps.
 * assumes a 4-bit register offset taken from the low address bits.
 */
package phssl_pkg;

    // ******************************
    // register offsets
    // ******************************
    localparam logic [3:0] REG_PDA  = 4'h0;
    localparam logic [3:0] REG_PORTA_ALT_DATA_ONE = 4'h1;
    localparam logic [3:0] REG_PORTA_ALT_DATA_TWO = 4'h2;
    localparam logic [3:0] REG_PDB  = 4'h3;
    localparam logic [3:0] REG_FSEL = 4'hb;
    localparam logic [3:0] REG_PORTB_ALT_DATA_ONE = 4'hc;
    localparam logic [3:0] REG_PORTB_ALT_DATA_TWO = 4'hd;
    localparam logic [3:0] REG_HSR  = 4'he;
    localparam logic [3:0] REG_HWR  = 4'hf;

    // ******************************
    // fields and reset values
    // ******************************
    localparam int         NCH       = 4;
    localparam int         FSEL_LSB  = 4;
    localparam int         PINC_LSB  = 4;
    localparam int         PIN_A1    = 4;
    localparam int         PIN_B1    = 6;
    localparam logic [3:0] FSEL_RST  = 4'h0;
    localparam logic [3:0] NIB_ZERO  = 4'h0;
    localparam logic [2:0] HSR_PAD   = 3'h0;
    localparam logic [7:0] BYTE_ZERO = 8'h00;

    // channel order = status bit: a1, b1, a2, b2
    // pin select index within pc4..pc7, channel 3 in the top field
    localparam logic [7:0]  CH_PIN = {2'h3, 2'h1, 2'h2, 2'h0};
    // data register whose access services each channel
    localparam logic [15:0] CH_REG = {REG_PORTB_ALT_DATA_TWO, REG_PORTA_ALT_DATA_TWO,
                                      REG_PORTB_ALT_DATA_ONE, REG_PORTA_ALT_DATA_ONE};

endpackage : phssl_pkg

// ---- core/phssl_sync.sv ----
/*
 * two flip-flop synchroniser for pin inputs.
 * assumes the inputs are quasi-static relative to CLK.
 */
`timescale 1ns/1ps
module phssl_sync
    import phssl_pkg::*;
#(
    parameter int W = 8
)
(
    // clock and reset
    input  wire logic         clk,
    input  wire logic         rst,
    // data
    input  wire logic [W-1:0] d_in,
    output logic      [W-1:0] d_out
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } phssl_sync_st_t;

    phssl_sync_st_t st_reg;
    phssl_sync_st_t st_next;

    // refuse widths the packed state cannot hold
    if (W < 1)
    begin : g_bad_width
        $error("phssl_sync: W must be positive");
    end

    always_comb
    begin
        st_next.s1 = d_in;
        st_next.s2 = st_reg.s1;
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst) st_reg <= '0;
        else     st_reg <= st_next;
    end

    assign d_out = st_reg.s2;

endmodule : phssl_sync

// ---- core/phssl_chan.sv ----
/*
 * one handshake channel: event flag plus overrun warning.
 * assumes event and clear pulses come from logic on CLK.
 */
`timescale 1ns/1ps
module phssl_chan
    import phssl_pkg::*;
(
    // clock and reset
    input  wire logic clk,
    input  wire logic rst,
    // strobes
    input  wire logic evt,
    input  wire logic flag_clr,
    input  wire logic warn_clr,
    // state
    output logic      flag,
    output logic      warn
);
    typedef struct packed {
        logic flag;
        logic warn;
    } phssl_chan_st_t;

    phssl_chan_st_t st_reg;
    phssl_chan_st_t st_next;

    always_comb
    begin
        // an event in the clearing cycle still lands
        st_next.flag = evt | (st_reg.flag & ~flag_clr);
        st_next.warn = (evt & st_reg.flag)
                     | (st_reg.warn & ~warn_clr);
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst) st_reg <= '0;
        else     st_reg <= st_next;
    end

    assign flag = st_reg.flag;
    assign warn = st_reg.warn;

endmodule : phssl_chan

// ---- core/phssl_top.sv ----
/*
 * port c function select with handshake status and warning flags,
 * reached over a multiplexed address/data bus.
 * assumes the handshake control registers, port data latches and the
 * port c direction register live elsewhere and feed in on CLK.
 */
`timescale 1ns/1ps
module phssl_top
    import phssl_pkg::*;
(
    // system
    input  wire logic       CLK,
    input  wire logic       RST,
    // multiplexed bus pins
    input  wire logic       BUS_AS,
    input  wire logic       BUS_DS,
    input  wire logic       BUS_RW,
    input  wire logic       BUS_CS,
    input  wire logic [7:0] AD_IN,
    output logic      [7:0] AD_OUT,
    output logic            AD_OE_N,
    // port c pins and neighbouring registers
    input  wire logic [7:0] PC_PIN,
    input  wire logic [7:0] PORTC_DIRECTION,
    input  wire logic [3:0] HS_INPUT_EN,
    input  wire logic [3:0] HS_RISE_EDGE,
    input  wire logic [3:0] HS_IRQ_EN,
    // results
    output logic      [7:0] PC_DIR_EFF,
    output logic      [3:0] PIN_FUNCTION_SELECT,
    output logic            COMBINED_INTERRUPT_FLAG,
    output logic      [3:0] HS_ACCESS,
    output logic            LATCH_WR_A,
    output logic            LATCH_WR_B,
    output logic      [7:0] LATCH_DATA
);
    // ******************************
    // state
    // ******************************
    typedef struct packed {
        logic [3:0] addr;
        logic       as_q;
        logic       ds_q;
        logic       rw_q;
        logic       cs_q;
        logic [7:0] wdat;
        logic [3:0] pin_q;
        logic [3:0] fsel;
        logic       buf_v;
        logic [1:0] buf_idx;
        logic       buf_w;
        logic       combined_interrupt_flag;
        logic [7:0] ad_out;
        logic       ad_oe_n;
        logic [7:0] dir_eff;
        logic       wr_a;
        logic       wr_b;
        logic [7:0] ldat;
        logic [3:0] acc;
    } phssl_state_t;

    phssl_state_t st_reg;
    phssl_state_t st_next;

    logic [15:0]    sync_in;
    logic [15:0]    sync_out;
    logic           as_s;
    logic           ds_s;
    logic           rw_s;
    logic           cs_s;
    logic [7:0]     ad_s;
    logic [3:0]     pin_s;
    logic           acc_end;
    logic           rd_end;
    logic           wr_end;
    logic           hwr_rd;
    logic [3:0]     evt;
    logic [3:0]     clr;
    logic [3:0]     wclr;
    logic [3:0]     flag;
    logic [3:0]     warn;
    logic [7:0]     rdata;

    // ******************************
    // pin synchronisers
    // ******************************
    assign sync_in = {BUS_AS, BUS_DS, BUS_RW, BUS_CS, AD_IN,
                      PC_PIN[PINC_LSB +: 4]};

    phssl_sync #(.W(16)) u_sync (
        .clk   (CLK),
        .rst   (RST),
        .d_in  (sync_in),
        .d_out (sync_out)
    );

    assign as_s  = sync_out[15];
    assign ds_s  = sync_out[14];
    assign rw_s  = sync_out[13];
    assign cs_s  = sync_out[12];
    assign ad_s  = sync_out[11:4];
    assign pin_s = sync_out[3:0];

    // ******************************
    // bus cycle decode
    // ******************************
    // effects act once, at the end of the data strobe
    assign acc_end = st_reg.ds_q & ~ds_s & st_reg.cs_q;
    assign rd_end  = acc_end & st_reg.rw_q;
    assign wr_end  = acc_end & ~st_reg.rw_q;
    assign hwr_rd  = rd_end & (st_reg.addr == REG_HWR);

    // ******************************
    // channels
    // ******************************
    genvar gi;
    generate
        for (gi = 0; gi < NCH; gi++)
        begin : g_ch
            logic [1:0] pidx;
            logic       edge_ok;
            assign pidx    = CH_PIN[2*gi +: 2];
            assign edge_ok = (pin_s[pidx] ^ st_reg.pin_q[pidx])
                           & (pin_s[pidx] == HS_RISE_EDGE[gi]);
            // only handshake-selected pins may post events
            assign evt[gi] = st_reg.fsel[pidx] & HS_INPUT_EN[gi]
                           & edge_ok;
            assign clr[gi] = acc_end
                           & (st_reg.addr == CH_REG[4*gi +: 4]);
            assign wclr[gi] = hwr_rd & st_reg.buf_v & st_reg.buf_w
                            & (st_reg.buf_idx == 2'(gi));

            phssl_chan u_chan (
                .clk      (CLK),
                .rst      (RST),
                .evt      (evt[gi]),
                .flag_clr (clr[gi]),
                .warn_clr (wclr[gi]),
                .flag     (flag[gi]),
                .warn     (warn[gi])
            );
        end
    endgenerate

    // ******************************
    // read data
    // ******************************
    always_comb
    begin
        if (st_reg.addr == REG_FSEL)
            rdata = {st_reg.fsel, NIB_ZERO};
        else if (st_reg.addr == REG_HSR)
            rdata = {st_reg.combined_interrupt_flag, HSR_PAD, flag};
        else if (st_reg.addr == REG_HWR)
            rdata = {NIB_ZERO, warn};
        else
            rdata = BYTE_ZERO;
    end

    // ******************************
    // next state
    // ******************************
    always_comb
    begin
        st_next       = st_reg;
        st_next.as_q  = as_s;
        st_next.ds_q  = ds_s;
        st_next.rw_q  = rw_s;
        st_next.cs_q  = cs_s;
        st_next.wdat  = ad_s;
        st_next.pin_q = pin_s;
        st_next.wr_a  = 1'b0;
        st_next.wr_b  = 1'b0;
        st_next.acc   = clr;
        if (st_reg.as_q && !as_s)
            st_next.addr = ad_s[3:0];
        // status register has no write path at all
        if (wr_end && st_reg.addr == REG_FSEL)
            st_next.fsel = st_reg.wdat[FSEL_LSB +: 4];
        if (wr_end && st_reg.addr == REG_PDA)
            st_next.wr_a = 1'b1;
        if (wr_end && (st_reg.addr == REG_PDB
                       || st_reg.addr == REG_PORTB_ALT_DATA_ONE))
            st_next.wr_b = 1'b1;
        st_next.ldat = st_reg.wdat;
        // a newer data read replaces the buffered warning
        if (hwr_rd)
            st_next.buf_v = 1'b0;
        for (int i = 0; i < NCH; i++)
        begin
            if (rd_end && st_reg.addr == CH_REG[4*i +: 4])
            begin
                st_next.buf_v   = 1'b1;
                st_next.buf_idx = 2'(i);
                st_next.buf_w   = warn[i];
            end
        end
        st_next.combined_interrupt_flag = |(flag & HS_IRQ_EN);
        st_next.dir_eff = PORTC_DIRECTION;
        if (st_reg.fsel[PIN_A1 - PINC_LSB])
            st_next.dir_eff[PIN_A1] = 1'b0;
        if (st_reg.fsel[PIN_B1 - PINC_LSB])
            st_next.dir_eff[PIN_B1] = 1'b0;
        if (ds_s && rw_s && cs_s && (st_reg.addr == REG_FSEL
            || st_reg.addr == REG_HSR || st_reg.addr == REG_HWR))
        begin
            st_next.ad_oe_n = 1'b0;
            st_next.ad_out  = rdata;
        end
        else
        begin
            st_next.ad_oe_n = 1'b1;
            st_next.ad_out  = BYTE_ZERO;
        end
    end

    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
        begin
            st_reg         <= '0;
            st_reg.fsel    <= FSEL_RST;
            st_reg.combined_interrupt_flag    <= 1'b0;
            st_reg.ad_oe_n <= 1'b1;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    // ******************************
    // outputs
    // ******************************
    assign AD_OUT                  = st_reg.ad_out;
    assign AD_OE_N                 = st_reg.ad_oe_n;
    assign PC_DIR_EFF              = st_reg.dir_eff;
    assign PIN_FUNCTION_SELECT     = st_reg.fsel;
    assign COMBINED_INTERRUPT_FLAG = st_reg.combined_interrupt_flag;
    assign HS_ACCESS               = st_reg.acc;
    assign LATCH_WR_A              = st_reg.wr_a;
    assign LATCH_WR_B              = st_reg.wr_b;
    assign LATCH_DATA              = st_reg.ldat;

    // ******************************
    // assertions
    // ******************************
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);

    a_fsel_write: assert property (wr_end && st_reg.addr == REG_FSEL
        |=> st_reg.fsel == $past(st_reg.wdat[7:4]))
        else $error("select write not stored");
    a_dir_force: assert property (st_reg.fsel[0] |=> !PC_DIR_EFF[4])
        else $error("strobe pin a left as output");
    a_no_evt_unsel: assert property (!st_reg.fsel[0] |-> !evt[0])
        else $error("event on unselected pin");
    a_evt_sets: assert property (evt[0] |=> flag[0])
        else $error("event did not set flag");
    a_clr_flag: assert property (clr[1] && !evt[1] |=> !flag[1])
        else $error("access did not clear flag");
    a_evt_wins: assert property (clr[2] && evt[2] |=> flag[2])
        else $error("event lost against clear");
    a_irq_flag: assert property (##1 COMBINED_INTERRUPT_FLAG
        == $past(|(flag & HS_IRQ_EN)))
        else $error("combined flag wrong");
    a_warn_set: assert property (evt[3] && flag[3] |=> warn[3])
        else $error("overrun warning missed");
    a_warn_keep: assert property (hwr_rd && !st_reg.buf_v
        |=> ($past(warn) & ~warn) == 4'h0)
        else $error("warning cleared without latch");
    a_warn_one: assert property (hwr_rd
        |=> (($past(warn) & ~warn)
             & ~(4'h1 << $past(st_reg.buf_idx))) == 4'h0)
        else $error("other warning cleared");
    a_hwr_upper: assert property ($fell(AD_OE_N)
        && $past(st_reg.addr) == REG_HWR |-> AD_OUT[7:4] == 4'h0)
        else $error("warning upper bits not zero");
    a_hsr_ro: assert property (wr_end && st_reg.addr == REG_HSR
        && evt == 4'h0 |=> flag == $past(flag))
        else $error("status changed by write");
    a_latch_b: assert property (wr_end && st_reg.addr == REG_PORTB_ALT_DATA_TWO
        |=> !LATCH_WR_B)
        else $error("second port b write hit latch");

    c_overrun: cover property (evt[0] && flag[0]);
    c_warn_clear: cover property (wclr != 4'h0);
    c_irq: cover property ($rose(COMBINED_INTERRUPT_FLAG));

endmodule : phssl_top

// ---- tb/phssl_cpu_model.sv ----
/*
 * bus master model: address-then-data cycles toward the block.
 * assumes a free-running clk and a caller that waits out reset.
 */
`timescale 1ns/1ps
module phssl_cpu_model
(
    // clock
    input  wire logic       clk,
    // bus pins toward the device
    output logic            bus_as,
    output logic            bus_ds,
    output logic            bus_rw,
    output logic            bus_cs,
    output logic      [7:0] ad_in
);
    // ********
    // bus cycles
    // ********
    initial
    begin
        bus_as = 1'b0;
        bus_ds = 1'b0;
        bus_rw = 1'b1;
        bus_cs = 1'b0;
        ad_in  = 8'h5a;
    end

    // released lines flip each cycle so a stale byte never looks valid
    task automatic hold(input int n, input logic flip);
        repeat (n)
        begin
            @(posedge clk);
            if (flip)
                ad_in <= ~ad_in;
        end
    endtask : hold

    // phases of at least four cycles clear the three-cycle minimum after the syncs
    task automatic access(input logic rd, input logic [3:0] off,
                          input logic [7:0] wdata);
        @(posedge clk);
        bus_as <= 1'b1;
        ad_in  <= {4'h0, off};
        hold(4, 1'b0);
        bus_as <= 1'b0;
        hold(4, 1'b0);
        bus_ds <= 1'b1;
        bus_rw <= rd;
        bus_cs <= 1'b1;
        if (rd)
            ad_in <= ~ad_in;
        else
            ad_in <= wdata;
        hold(6, rd);
        bus_ds <= 1'b0;
        hold(4, rd);
        bus_cs <= 1'b0;
        hold(6, 1'b1);
    endtask : access
endmodule : phssl_cpu_model

// ---- tb/phssl_top_tb.sv ----
/*
 * self-checking bench for phssl_top driven by the bus master model.
 * assumes phssl_pkg, the design and tb/phssl_cpu_model are compiled first.
 */
`timescale 1ns/1ps
`define CHK(got, exp) \
    begin \
        total_checks++; \
        if ((got) !== (exp)) \
        begin \
            failures++; \
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp); \
        end \
    end
module phssl_top_tb
    import phssl_pkg::*;
;
    logic        clk = 1'b0;
    logic        rst, bus_as, bus_ds, bus_rw, bus_cs, oe_n, combined_interrupt_flag;
    logic        wr_a, wr_b, oe_prev;
    logic [7:0]  ad_in, ad_out, pc_pin, pc_dir, dir_eff, latch_data, sel, wd;
    logic [3:0]  in_en, rise, irq_en, fsel_out, flag, warn, acc, anote;
    logic [15:0] note;
    logic [9:0]  lnote;
    logic [15:0] rd_q[$];
    logic [9:0]  lt_q[$];
    logic [3:0]  acc_q[$];
    int          failures = 0;
    int          total_checks = 0;
    int          pin_of[4] = '{4, 6, 5, 7};
    logic [3:0]  reg_of[4] = '{REG_PORTA_ALT_DATA_ONE, REG_PORTB_ALT_DATA_ONE, REG_PORTA_ALT_DATA_TWO, REG_PORTB_ALT_DATA_TWO};

    always #50 clk = ~clk;

    phssl_top phssl_top_inst (
        .CLK(clk), .RST(rst), .BUS_AS(bus_as), .BUS_DS(bus_ds),
        .BUS_RW(bus_rw), .BUS_CS(bus_cs), .AD_IN(ad_in), .AD_OUT(ad_out),
        .AD_OE_N(oe_n), .PC_PIN(pc_pin), .PORTC_DIRECTION(pc_dir),
        .HS_INPUT_EN(in_en), .HS_RISE_EDGE(rise), .HS_IRQ_EN(irq_en),
        .PC_DIR_EFF(dir_eff), .PIN_FUNCTION_SELECT(fsel_out),
        .COMBINED_INTERRUPT_FLAG(combined_interrupt_flag), .HS_ACCESS(acc),
        .LATCH_WR_A(wr_a), .LATCH_WR_B(wr_b), .LATCH_DATA(latch_data));

    phssl_cpu_model phssl_cpu_model_inst (
        .clk(clk), .bus_as(bus_as), .bus_ds(bus_ds), .bus_rw(bus_rw),
        .bus_cs(bus_cs), .ad_in(ad_in));

    // ********
    // helpers
    // ********
    task automatic results;
        $display("checks=%0d failures=%0d", total_checks, failures);
        if (failures == 0 && total_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : results

    // note is {mask, expected byte}; undefined status bits are masked off
    task automatic rd(input logic [3:0] off, input logic [7:0] m,
                      input logic [7:0] e);
        rd_q.push_back({m, e & m});
        phssl_cpu_model_inst.access(1'b1, off, 8'h00);
    endtask : rd

    task automatic wr(input logic [3:0] off, input logic [7:0] d);
        phssl_cpu_model_inst.access(1'b0, off, d);
    endtask : wr

    // one full pulse gives exactly one active edge whatever the polarity
    task automatic pulse(input int ch);
        @(posedge clk);
        pc_pin[pin_of[ch]] <= 1'b1;
        repeat (4) @(posedge clk);
        pc_pin[pin_of[ch]] <= 1'b0;
        repeat (6) @(posedge clk);
        if (sel[pin_of[ch]] && in_en[ch])
        begin
            warn[ch] = warn[ch] | flag[ch];
            flag[ch] = 1'b1;
        end
    endtask : pulse

    function automatic logic [7:0] hsr_exp();
        return {|(flag & irq_en), 3'h0, flag};
    endfunction : hsr_exp

    always @(negedge clk)
    begin
        if (oe_n === 1'b0 && oe_prev === 1'b1)
        begin
            `CHK(rd_q.size() > 0, 1'b1)
            if (rd_q.size() > 0)
            begin
                note = rd_q.pop_front();
                `CHK(ad_out & note[15:8], note[7:0])
            end
        end
        if (wr_a === 1'b1 || wr_b === 1'b1)
        begin
            `CHK(lt_q.size() > 0, 1'b1)
            if (lt_q.size() > 0)
            begin
                lnote = lt_q.pop_front();
                `CHK({wr_a, wr_b, latch_data}, lnote)
            end
        end
        if (acc !== 4'h0)
        begin
            `CHK(acc_q.size() > 0, 1'b1)
            if (acc_q.size() > 0)
            begin
                anote = acc_q.pop_front();
                `CHK(acc, anote)
            end
        end
        oe_prev = oe_n;
    end

    // run is near 3000 cycles; ten times that marks a hang
    initial
    begin
        #3_000_000;
        failures++;
        results();
    end

    // ********
    // scenarios
    // ********
    initial
    begin
        rst = 1'b1;
        pc_pin = 8'h00;
        pc_dir = 8'h00;
        in_en = 4'h0;
        rise = 4'h0;
        irq_en = 4'h0;
        flag = 4'h0;
        warn = 4'h0;
        sel = 8'h00;
        oe_prev = 1'b1;
        void'($urandom(32'h2938));
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        pc_dir <= 8'($urandom);
        repeat (4) @(posedge clk);
        @(negedge clk);
        `CHK(fsel_out, 4'h0)
        `CHK(dir_eff, pc_dir)
        rd(REG_HSR, 8'hff, 8'h00);
        rd(REG_HWR, 8'hff, 8'h00);
        rd(REG_FSEL, 8'hf0, 8'h00);
        for (int r = 0; r < 4; r++)
        begin
            // direction and control go in before the select write
            @(posedge clk);
            in_en  <= 4'($urandom | $urandom);
            rise   <= 4'($urandom);
            irq_en <= 4'($urandom);
            pc_dir <= 8'($urandom);
            sel     = 8'($urandom | $urandom);
            wr(REG_FSEL, sel);
            rd(REG_FSEL, 8'hf0, sel);
            @(negedge clk);
            `CHK(fsel_out, sel[7:4])
            `CHK(dir_eff, pc_dir & ~{1'b0, sel[6], 1'b0, sel[4], 4'h0})
            for (int ch = 0; ch < 4; ch++)
                repeat ($urandom % 3) pulse(ch);
            @(negedge clk);
            `CHK(combined_interrupt_flag, |(flag & irq_en))
            rd(REG_HSR, 8'h8f, hsr_exp());
            wr(REG_HSR, 8'hff);
            rd(REG_HSR, 8'h8f, hsr_exp());
            rd(REG_HWR, 8'hff, {4'h0, warn});
            // service in the recommended order: status, data, warnings
            for (int ch = 0; ch < 4; ch++)
            begin
                wd = 8'($urandom);
                acc_q.push_back(4'h1 << ch);
                if (r[0])
                begin
                    if (reg_of[ch] == REG_PORTB_ALT_DATA_ONE)
                        lt_q.push_back({2'b01, wd});
                    wr(reg_of[ch], wd);
                end
                else
                    phssl_cpu_model_inst.access(1'b1, reg_of[ch], 8'h00);
                flag[ch] = 1'b0;
                rd(REG_HWR, 8'hff, {4'h0, warn});
                if (!r[0])
                    warn[ch] = 1'b0;
                rd(REG_HWR, 8'hff, {4'h0, warn});
                rd(REG_HSR, 8'h8f, hsr_exp());
            end
        end
        // an event in the very cycle its flag is cleared must survive
        @(posedge clk);
        in_en <= 4'hf;
        sel    = 8'h20;
        wr(REG_FSEL, sel);
        acc_q.push_back(4'h4);
        fork
            wr(REG_PORTA_ALT_DATA_TWO, 8'h00);
            begin
                repeat (rise[2] ? 14 : 10) @(posedge clk);
                pulse(2);
            end
        join
        rd(REG_HSR, 8'h8f, hsr_exp());
        for (int k = 0; k < 2; k++)
        begin
            wd = 8'($urandom);
            lt_q.push_back({k == 0, k == 1, wd});
            wr(k == 0 ? REG_PDA : REG_PDB, wd);
        end
        repeat (10) @(posedge clk);
        // second reset with the select and a flag in use
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        flag = 4'h0;
        warn = 4'h0;
        repeat (4) @(posedge clk);
        @(negedge clk);
        `CHK(fsel_out, 4'h0)
        `CHK(dir_eff, pc_dir)
        rd(REG_HSR, 8'hff, 8'h00);
        rd(REG_HWR, 8'hff, 8'h00);
        repeat (10) @(posedge clk);
        `CHK(rd_q.size() + lt_q.size() + acc_q.size(), 0)
        results();
    end
endmodule : phssl_top_tb
